// ---- mrd_pkg.sv ----
// Package: constants for the DDR3 mode-register decode block
package mrd_pkg;

    // ========================================
    // Command decode (cs, ras, cas, we low)
    localparam logic [2:0] MR_SEL_ZERO    = 3'h0;
    localparam logic [2:0] MR_SEL_ONE     = 3'h1;
    localparam logic [2:0] MR_SEL_TWO     = 3'h2;

    // ========================================
    // Mode register zero field positions
    localparam int MR0_BL_LSB      = 0;
    localparam int MR0_BT_BIT      = 3;
    localparam int MR0_DLLRST_BIT  = 8;
    localparam int MR0_WR_LSB      = 9;
    localparam int MR0_PPD_BIT     = 12;
    localparam int MR0_CL_BIT0     = 2;
    localparam int MR0_CL_LSB      = 4;

    // ========================================
    // Mode register one field positions
    localparam int MR1_DLLDIS_BIT  = 0;
    localparam int MR1_DS_BIT0     = 1;
    localparam int MR1_DS_BIT1     = 5;
    localparam int MR1_RTT_BIT0    = 2;
    localparam int MR1_RTT_BIT1    = 6;
    localparam int MR1_RTT_BIT2    = 9;
    localparam int MR1_AL_LSB      = 3;
    localparam int MR1_WLEV_BIT    = 7;
    localparam int MR1_QOFF_BIT    = 12;

    // ========================================
    // Mode register two field positions
    localparam int MR2_CWL_LSB     = 3;
    localparam int MR2_RTTWR_LSB   = 9;

    // ========================================
    // Reset values, burst-length encodings and chop write pull-in
    localparam logic [15:0] MR_RESET_VAL  = 16'h0000;
    localparam logic [1:0]  BL_FIXED_BL8  = 2'h0;
    localparam logic [1:0]  BL_ON_FLY     = 2'h1;
    localparam logic [1:0]  BL_FIXED_BC4  = 2'h2;
    localparam logic [2:0]  BC4_PULL_IN   = 3'h2;

    typedef enum logic [1:0] {
        MRD_IDLE  = 2'b00,
        MRD_BURST = 2'b01
    } mrd_state_t;

endpackage

// ---- mrd_beat_order.sv ----
// Column index of one burst beat from start column and burst type
module mrd_beat_order (
    // Burst setup
    input  wire logic [2:0] start_col_i,
    input  wire logic       interleave_i,
    input  wire logic       is_write_i,
    // Beat position
    input  wire logic [2:0] beat_i,
    output logic      [2:0] col_o
);

    logic [2:0] seq_col;
    logic [2:0] int_col;
    logic [2:0] wr_col;

    // Low bits rotate, upper bit flips for the second half
    assign seq_col = {start_col_i[2] ^ beat_i[2],
                      2'(start_col_i[1:0] + beat_i[1:0])};
    assign int_col = start_col_i ^ beat_i;
    // Writes ignore low start bits; bit 2 picks the half
    assign wr_col  = {start_col_i[2] ^ beat_i[2], beat_i[1:0]};
    assign col_o   = is_write_i ? wr_col
                                : (interleave_i ? int_col : seq_col);

endmodule // mrd_beat_order

// ---- mrd_decode.sv ----
// Main module: mode-register decode and burst sequencing
// Operation
// - A3 selects sequential or interleaved order
// - A0-A1 choose fixed chop, eight, or on-the-fly
// - Sequential: low bits rotate, halves follow
// - Interleaved: start column XOR beat count
// - Chop-four read drives four beats only
// - Writes ignore low start column bits
// - Fixed chop pulls write timing two clocks
// - DLL reset bit clears itself after launch
// - A9-A11 hold write recovery cycle count
// - A12 selects slow or fast power-down exit
// - DLL follows self-refresh entry and exit
// - A1 and A5 set driver strength
// - Write termination applies without nominal
// - Commands delayed by added latency
// - Register one A12 disconnects outputs
module mrd_decode #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              clk_en_i,
    // Command pins, registered on the clock edge
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic [2:0]        bank_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    // Power state events
    input  wire logic              self_refresh_entry_i,
    input  wire logic              self_refresh_exit_i,
    input  wire logic              pd_exit_i,
    // Burst column and output control
    output logic      [2:0]        burst_col_o,
    output logic                   burst_valid_o,
    output logic                   is_write_o,
    output logic                   dq_drive_en_o,
    output logic                   write_timing_ref_o,
    // Decoded fields
    output logic                   interleave_o,
    output logic      [1:0]        burst_len_mode_o,
    output logic      [2:0]        write_recovery_o,
    output logic                   fast_pd_exit_o,
    output logic      [3:0]        column_latency_o,
    output logic      [1:0]        drive_strength_o,
    output logic      [2:0]        nom_term_o,
    output logic      [1:0]        write_term_o,
    output logic      [1:0]        added_latency_o,
    output logic      [2:0]        write_column_latency_o,
    output logic                   write_leveling_o,
    output logic                   outputs_off_o,
    output logic                   dll_on_o,
    output logic                   dll_reset_pulse_o,
    output logic                   pd_slow_exit_o
);

    // ========================================
    // Command decode
    logic mrs_cmd;
    logic rd_cmd;
    logic wr_cmd;
    logic col_cmd;
    assign mrs_cmd = ~cs_n_i & ~ras_n_i & ~cas_n_i & ~we_n_i;
    assign col_cmd = ~cs_n_i & ras_n_i & ~cas_n_i;
    assign rd_cmd  = col_cmd & we_n_i;
    assign wr_cmd  = col_cmd & ~we_n_i;

    // ========================================
    // Mode registers
    logic [ADDR_W-1:0] mr0_r;
    logic [ADDR_W-1:0] mr1_r;
    logic [ADDR_W-1:0] mr2_r;
    logic              dll_off_sr_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mr0_r        <= ADDR_W'(mrd_pkg::MR_RESET_VAL);
            mr1_r        <= ADDR_W'(mrd_pkg::MR_RESET_VAL);
            mr2_r        <= ADDR_W'(mrd_pkg::MR_RESET_VAL);
            dll_off_sr_r <= 1'b0;
        end else if (clk_en_i) begin
            // Whole register replaced by supplied bits
            if (mrs_cmd && bank_i == mrd_pkg::MR_SEL_ZERO) begin
                mr0_r <= addr_i;
            end else if (mr0_r[mrd_pkg::MR0_DLLRST_BIT]) begin
                mr0_r[mrd_pkg::MR0_DLLRST_BIT] <= 1'b0;
            end
            if (mrs_cmd && bank_i == mrd_pkg::MR_SEL_ONE) begin
                mr1_r <= addr_i;
            end
            if (mrs_cmd && bank_i == mrd_pkg::MR_SEL_TWO) begin
                mr2_r <= addr_i;
            end
            // Exit wins if both arrive together
            if (self_refresh_exit_i) begin
                dll_off_sr_r <= 1'b0;
            end else if (self_refresh_entry_i) begin
                dll_off_sr_r <= 1'b1;
            end
        end
    end

    // ========================================
    // Field decode
    assign burst_len_mode_o = mr0_r[mrd_pkg::MR0_BL_LSB +: 2];
    assign interleave_o     = mr0_r[mrd_pkg::MR0_BT_BIT];
    assign write_recovery_o = mr0_r[mrd_pkg::MR0_WR_LSB +: 3];
    assign fast_pd_exit_o   = mr0_r[mrd_pkg::MR0_PPD_BIT];
    assign column_latency_o = {mr0_r[mrd_pkg::MR0_CL_LSB +: 3],
                               mr0_r[mrd_pkg::MR0_CL_BIT0]};
    assign drive_strength_o = {mr1_r[mrd_pkg::MR1_DS_BIT1],
                               mr1_r[mrd_pkg::MR1_DS_BIT0]};
    assign nom_term_o       = {mr1_r[mrd_pkg::MR1_RTT_BIT2],
                               mr1_r[mrd_pkg::MR1_RTT_BIT1],
                               mr1_r[mrd_pkg::MR1_RTT_BIT0]};
    assign added_latency_o  = mr1_r[mrd_pkg::MR1_AL_LSB +: 2];
    assign write_leveling_o = mr1_r[mrd_pkg::MR1_WLEV_BIT];
    assign outputs_off_o    = mr1_r[mrd_pkg::MR1_QOFF_BIT];
    assign write_column_latency_o = mr2_r[mrd_pkg::MR2_CWL_LSB +: 3];
    // Write termination stands even with nominal disabled
    assign write_term_o     = mr2_r[mrd_pkg::MR2_RTTWR_LSB +: 2];
    assign dll_on_o = ~mr1_r[mrd_pkg::MR1_DLLDIS_BIT]
                      & ~dll_off_sr_r;
    assign dll_reset_pulse_o = mr0_r[mrd_pkg::MR0_DLLRST_BIT];
    assign pd_slow_exit_o = pd_exit_i & ~fast_pd_exit_o;

    // ========================================
    // Added latency: internal command delayed by al cycles
    logic [3:0] al_cycles;
    assign al_cycles = (added_latency_o == 2'h1) ? 4'(column_latency_o - 4'h1)
                     : (added_latency_o == 2'h2) ? 4'(column_latency_o - 4'h2)
                     : 4'h0;

    logic [3:0] al_cnt_r;
    logic       pend_r;
    logic       pend_wr_r;
    logic       pend_bc4_r;
    logic       pend_otf_r;
    logic [2:0] pend_col_r;
    logic       chop_now;
    assign chop_now = (burst_len_mode_o == mrd_pkg::BL_FIXED_BC4) ||
                      ((burst_len_mode_o == mrd_pkg::BL_ON_FLY) &&
                       ~addr_i[12]);

    // ========================================
    // Burst sequencer
    mrd_pkg::mrd_state_t state_r;
    logic [2:0] beat_r;
    logic       bc4_r;
    logic       otf_r;
    logic [2:0] col_r;
    logic       issue;
    // Held back until the running burst has ended
    assign issue = pend_r && al_cnt_r == 4'h0
                   && state_r == mrd_pkg::MRD_IDLE;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_r     <= 1'b0;
            pend_wr_r  <= 1'b0;
            pend_bc4_r <= 1'b0;
            pend_otf_r <= 1'b0;
            pend_col_r <= 3'h0;
            al_cnt_r   <= 4'h0;
        end else if (clk_en_i) begin
            if (col_cmd) begin
                pend_r     <= 1'b1;
                pend_wr_r  <= wr_cmd;
                pend_bc4_r <= chop_now;
                pend_otf_r <= burst_len_mode_o == mrd_pkg::BL_ON_FLY;
                pend_col_r <= addr_i[2:0];
                al_cnt_r   <= al_cycles;
            end else if (issue) begin
                pend_r <= 1'b0;
            end else if (al_cnt_r != 4'h0) begin
                al_cnt_r <= al_cnt_r - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r    <= mrd_pkg::MRD_IDLE;
            beat_r     <= 3'h0;
            bc4_r      <= 1'b0;
            otf_r      <= 1'b0;
            col_r      <= 3'h0;
            is_write_o <= 1'b0;
        end else if (clk_en_i) begin
            case (state_r)
                mrd_pkg::MRD_IDLE: begin
                    if (issue) begin
                        state_r    <= mrd_pkg::MRD_BURST;
                        beat_r     <= 3'h0;
                        bc4_r      <= pend_bc4_r;
                        otf_r      <= pend_otf_r;
                        col_r      <= pend_col_r;
                        is_write_o <= pend_wr_r;
                    end
                end
                mrd_pkg::MRD_BURST: begin
                    beat_r <= beat_r + 3'h1;
                    if (beat_r == 3'h7) begin
                        state_r <= mrd_pkg::MRD_IDLE;
                    end
                end
                default: state_r <= mrd_pkg::MRD_IDLE;
            endcase
        end
    end

    logic in_burst;
    logic [2:0] ord_col;
    logic [2:0] order_start;
    assign in_burst = state_r == mrd_pkg::MRD_BURST;
    // Eight-beat writes always run from column zero
    assign order_start = {col_r[2] & (bc4_r | ~is_write_o),
                          col_r[1:0]};

    mrd_beat_order u_order (
        .start_col_i  (order_start),
        .interleave_i (interleave_o),
        .is_write_i   (is_write_o),
        .beat_i       (beat_r),
        .col_o        (ord_col)
    );

    assign burst_col_o = ord_col;
    // Slots past four on a chop burst carry no data
    assign burst_valid_o = in_burst & ~(bc4_r & beat_r[2]);
    assign dq_drive_en_o = burst_valid_o & ~is_write_o
                           & ~outputs_off_o;

    // Write timing reference: fixed chop two clocks early
    logic [2:0] wref_beat;
    assign wref_beat = (bc4_r & ~otf_r) ? 3'(3'h7 - mrd_pkg::BC4_PULL_IN)
                                        : 3'h7;
    assign write_timing_ref_o = in_burst & is_write_o
                                & beat_r == wref_beat;

endmodule // mrd_decode

// ---- mrd_decode_props.sv ----
// Assertion checker for the mode-register decode block
module mrd_decode_props #(
    parameter int ADDR_W = 16
) (
    // Clock and command pins
    input wire logic              clk_i,
    input wire logic              reset_i,
    input wire logic              clk_en_i,
    input wire logic              cs_n_i,
    input wire logic              ras_n_i,
    input wire logic              cas_n_i,
    input wire logic              we_n_i,
    input wire logic [2:0]        bank_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic              pd_exit_i,
    // Watched outputs
    input wire logic              dq_drive_en_o,
    input wire logic              interleave_o,
    input wire logic [1:0]        burst_len_mode_o,
    input wire logic [1:0]        drive_strength_o,
    input wire logic              outputs_off_o,
    input wire logic              fast_pd_exit_o,
    input wire logic              dll_reset_pulse_o,
    input wire logic              pd_slow_exit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic mrs_w  = clk_en_i & ~(cs_n_i | ras_n_i | cas_n_i | we_n_i);
    wire logic mrs0_w = mrs_w & (bank_i == 3'h0);
    wire logic mrs1_w = mrs_w & (bank_i == 3'h1);

    bt_load_a: assert property (
        mrs0_w |=> interleave_o == $past(addr_i[3])) else $error("bt");
    bl_load_a: assert property (
        mrs0_w |=> burst_len_mode_o == $past(addr_i[1:0])) else $error("bl");
    dll_pulse_a: assert property (
        mrs0_w && addr_i[8] |=> dll_reset_pulse_o ##1 !dll_reset_pulse_o)
        else $error("dll reset pulse");
    slow_exit_a: assert property (
        pd_slow_exit_o == (pd_exit_i && !fast_pd_exit_o)) else $error("pd");
    drv_load_a: assert property (
        mrs1_w |=> drive_strength_o == $past({addr_i[5], addr_i[1]}))
        else $error("drive strength");
    qoff_drive_a: assert property (
        outputs_off_o |-> !dq_drive_en_o) else $error("driven while off");
    qoff_load_a: assert property (
        mrs1_w |=> outputs_off_o == $past(addr_i[12])) else $error("qoff");
    fld_hold_a: assert property (
        !mrs_w |=> $stable(interleave_o) && $stable(drive_strength_o))
        else $error("field changed without mode set");
    cover property (mrs0_w && addr_i[3]);
    cover property (dq_drive_en_o);
    cover property (pd_slow_exit_o);
endmodule // mrd_decode_props

bind mrd_decode mrd_decode_props #(.ADDR_W(ADDR_W)) i_props (.*);

// ---- mrd_ctrl_model.sv ----
// Controller model issuing commands to the decode block
module mrd_ctrl_model #(
    parameter int DLL_LOCK = 16
) (
    // Clock
    input  wire logic  clk_i,
    // Command pins
    output logic       cs_n_o,
    output logic       ras_n_o,
    output logic       cas_n_o,
    output logic       we_n_o,
    output logic [2:0] bank_o,
    output logic [15:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int ready_at = 0;
    initial {cs_n_o, ras_n_o, cas_n_o, we_n_o, bank_o, addr_o} = '1;
    always @(posedge clk_i) cyc <= cyc + 1;

    // Deselected lines are inverted so a stale command never looks valid
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a);
        @(posedge clk_i);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
        bank_o <= b;
        addr_o <= a;
        @(posedge clk_i);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {1'b1, ~c[2:0]};
        bank_o <= ~b;
        addr_o <= ~a;
    endtask

    task automatic mode_set(input logic [2:0] b, input logic [15:0] a);
        if (b == 3'h0 && a[8])
            ready_at = cyc + DLL_LOCK + 2;
        cmd(4'h0, b, a);
    endtask

    task automatic column(input logic wr, input logic [15:0] a);
        while (!wr && cyc < ready_at)
            @(posedge clk_i);
        cmd({3'b010, ~wr}, 3'h0, a);
    endtask
endmodule // mrd_ctrl_model

// ---- mrd_decode_tb.sv ----
// Self-checking testbench for the mode-register decode block
module mrd_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, reset_i = 1'b1;
    logic clk_en_i = 1'b1, pd_exit_i = 1'b0;
    logic self_refresh_entry_i = 1'b0, self_refresh_exit_i = 1'b0;
    logic burst_valid_o, is_write_o, dq_drive_en_o, write_timing_ref_o;
    logic interleave_o, fast_pd_exit_o, write_leveling_o, outputs_off_o;
    logic dll_on_o, dll_reset_pulse_o, pd_slow_exit_o;
    logic [1:0] burst_len_mode_o, drive_strength_o, write_term_o;
    logic [1:0] added_latency_o;
    logic [2:0] bank_i, burst_col_o, write_recovery_o, nom_term_o;
    logic [2:0] write_column_latency_o;
    logic [3:0] column_latency_o;
    logic [15:0] addr_i;
    int miscompares = 0;
    int num_checks = 0;

    mrd_decode i_dut (.*);
    mrd_ctrl_model #(.DLL_LOCK(20)) i_ctrl (.clk_i(clk_i), .cs_n_o(cs_n_i),
        .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
        .bank_o(bank_i), .addr_o(addr_i));

    task automatic check(input logic [15:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic results;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [2:0] col_of(logic [2:0] s, b, logic il, wr, ch);
        if (wr)
            return ch ? {s[2], b[1:0]} : b;
        if (il)
            return s ^ b;
        return {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction

    // Address bit 15 picks interleave, bit 14 a write
    task automatic burst(input logic [1:0] bl, input logic [15:0] a);
        logic [15:0] m;
        logic [2:0] e;
        logic ch;
        int n;
        int w;
        m = {4'h0, 3'($urandom), 2'h0, 3'($urandom), a[15], 1'b0, bl};
        ch = bl == mrd_pkg::BL_FIXED_BC4 || (bl == mrd_pkg::BL_ON_FLY && !a[12]);
        w = !a[14] ? 8 : (bl == mrd_pkg::BL_FIXED_BC4) ? 5 : 7;
        i_ctrl.mode_set(3'h0, m);
        @(negedge clk_i);
        check({interleave_o, burst_len_mode_o,
               write_recovery_o, column_latency_o},
              {m[3], bl, m[11:9], m[6:4], m[2]}, "mode zero fields");
        i_ctrl.column(a[14], a);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (burst_valid_o !== 1'b1 && n < 8);
        for (int b = 0; b < 8; b++) begin
            e = col_of(a[2:0], 3'(b), a[15], a[14], ch);
            check(burst_valid_o, !ch || b < 4, "beat valid");
            check(dq_drive_en_o, !a[14] && (!ch || b < 4), "drive");
            check(write_timing_ref_o, b == w, "write ref");
            if (!ch || b < 4)
                check(burst_col_o, e, "beat column");
            @(negedge clk_i);
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        results();
    end

    initial begin
        logic [15:0] a;
        void'($urandom(32'h249C9E30));
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            a = 16'($urandom) & 16'h10BA;
            a[4] = a[4] & ~a[3];
            {a[6], a[2]} = {i[0], ~i[0]};
            i_ctrl.mode_set(3'h1, a);
            @(negedge clk_i);
            check(drive_strength_o, {a[5], a[1]}, "drive strength");
            check({outputs_off_o, added_latency_o, nom_term_o,
                   write_leveling_o},
                  {a[12], a[4:3], a[9], a[6], a[2], a[7]}, "mode one fields");
        end
        i_ctrl.mode_set(3'h1, 16'h0000);
        for (int i = 0; i < 24; i++)
            burst(2'(i % 3), 16'($urandom));
        for (int k = 0; k < 2; k++) begin
            i_ctrl.mode_set(3'h0, {3'h0, k[0], 3'h0, 1'b1, 8'h00});
            @(negedge clk_i);
            check(dll_reset_pulse_o, 1'b1, "dll reset");
            @(negedge clk_i);
            check(dll_reset_pulse_o, 1'b0, "dll reset");
            @(posedge clk_i) pd_exit_i <= 1'b1;
            @(negedge clk_i);
            check(pd_slow_exit_o, !k[0], "pd exit");
            check(fast_pd_exit_o, k[0], "pd exit mode");
            @(posedge clk_i) pd_exit_i <= 1'b0;
        end
        burst(mrd_pkg::BL_FIXED_BL8, 16'h0005);
        @(posedge clk_i) self_refresh_entry_i <= 1'b1;
        @(posedge clk_i) self_refresh_entry_i <= 1'b0;
        @(negedge clk_i);
        check(dll_on_o, 1'b0, "refresh entry");
        @(posedge clk_i) self_refresh_exit_i <= 1'b1;
        @(posedge clk_i) self_refresh_exit_i <= 1'b0;
        @(negedge clk_i);
        check(dll_on_o, 1'b1, "refresh exit");
        // Clock enable held low so the following register one mode set is ignored
        @(posedge clk_i) clk_en_i <= 1'b0;
        i_ctrl.mode_set(3'h1, 16'h0022);
        @(negedge clk_i);
        check(drive_strength_o, 2'h0, "frozen");
        @(posedge clk_i) clk_en_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = 16'($urandom) & 16'h0638;
            a[10] = a[10] & ~a[9];
            i_ctrl.mode_set(3'h2, a);
            @(negedge clk_i);
            check({write_term_o, write_column_latency_o},
                  {a[10:9], a[5:3]}, "mode two fields");
        end
        i_ctrl.mode_set(3'h1, 16'h0001);
        i_ctrl.mode_set(3'h2, 16'h0000);
        @(negedge clk_i);
        check({dll_on_o, nom_term_o, write_term_o}, 6'h00,
              "dll off");
        results();
    end
endmodule // mrd_decode_tb
